// ### verilog/fes_defs.svh
// Offsets, field positions, fixed values and counts of the supervisor
`ifndef FES_DEFS_SVH
`define FES_DEFS_SVH
// Register indices; byte address is four times the index
`define FES_IDX_OPTION 8'h01
`define FES_IDX_STATUS 8'h02
`define FES_IDX_CNT1_MASK 8'h03
`define FES_IDX_CNT2_MASK 8'h04
`define FES_IDX_STORE_A 8'h05
`define FES_IDX_STORE_B 8'h06
`define FES_IDX_RESULT_A 8'h08
`define FES_IDX_RESULT_B 8'h09
`define FES_IDX_TRUSTED 8'h4f
`define FES_IDX_OFFSET_TIME 8'h50
`define FES_IDX_VAR_LIM 8'h51
`define FES_IDX_IRQ_MASK 8'h53
`define FES_IDX_PW_NOM 8'h56
`define FES_IDX_MAX_FLOW 8'h5c
`define FES_IDX_START_LEVEL 8'h6b
`define FES_IDX_IEH 8'h70
`define FES_IDX_CS_DATA2 8'h7d
`define FES_IDX_CS_USER 8'h7e
`define FES_IDX_CS_VENDOR 8'h7f
// Option word bit positions
`define FES_OPT_DOUBLE_MAX_KEEP 16
`define FES_OPT_LEVEL_TEST_REGULAR 23
`define FES_OPT_PULSE_ERR_SUPPRESS 21
`define FES_OPT_HW_ERR_ON_PULSE 22
`define FES_OPT_METHOD_LO 24
`define FES_OPT_METHOD_HI 25
`define FES_OPT_LEVEL_RATIO 26
`define FES_OPT_VEL_CHECK 27
`define FES_OPT_CNT_ENABLE 28
// Interrupt enable image: synchronous error interrupt bit
`define FES_IEH_SYNC_BIT 0
// Error flag positions
`define FES_ERR_HW_BIT 15
`define FES_ERR_FLOW_BIT 8
`define FES_ERR_VEL_BIT 9
`define FES_ERR_CS_BIT 10
// Regulation timing in measurements
`define FES_MEAS_CNT_W 5
`define FES_LEVEL_SLOT 5'h00
`define FES_PWR_SLOT 5'h10
`define FES_LONG_TERM_CNT 6'h20
// Fixed values
`define FES_WORD_ZERO 32'h00000000
`define FES_HALF_MAX 16'hffff
`define FES_METHOD_FIXED 2'h0
`define FES_METHOD_OFFSET 2'h2
`endif

// ### verilog/fes_pkg.sv
// Types of the flow error supervisor
package fes_pkg;
   typedef enum logic [1:0] {LV_OPERATE, LV_TRUSTED, LV_FALLBACK} fes_lv_t;

   typedef struct packed {
      logic hready;
      logic [31:0] rdata;
      logic wr_pend;
      logic [7:0] wr_idx;
      logic [31:0] option;
      logic [31:0] cnt1_mask;
      logic [31:0] cnt2_mask;
      logic [31:0] store_a;
      logic [31:0] store_b;
      logic [31:0] result_a;
      logic [31:0] result_b;
      logic [31:0] trusted;
      logic [31:0] offset_time;
      logic [31:0] var_lim;
      logic [31:0] irq_mask;
      logic [31:0] pw_nom;
      logic [31:0] max_flow;
      logic [31:0] start_level;
      logic [31:0] ieh;
      logic [31:0] cs_data2;
      logic [31:0] cs_user;
      logic [31:0] cs_vendor;
      logic [31:0] err_word;
      logic [31:0] flow;
      logic pulse_err;
      logic irq;
      logic [4:0] meas_cnt;
      logic [5:0] err_run;
      logic [15:0] amp;
      logic [31:0] summed_time_of_flight_ref;
      fes_lv_t lv_mode;
      logic started;
      logic [15:0] op_level;
      logic [15:0] level;
      logic trusted_sel;
      logic lvl_adj;
      logic pwr_reg;
   } fes_state_t;
endpackage : fes_pkg

// ### verilog/fes_count_step.sv
// One hourly error counter step with saturation and peak hold
`timescale 1ns/1ps
`include "fes_defs.svh"
module fes_count_step (
   input wire logic [15:0] cnt_in,
   input wire logic [15:0] peak_in,
   input wire logic event_in,
   input wire logic clear_in,
   input wire logic enable_in,
   output logic [15:0] next_cnt_out,
   output logic [15:0] next_peak_out
);
   // Clear on the hourly recall, count, then track the peak
   always_comb
   begin
      // An event in the recall cycle counts toward the new hour
      next_cnt_out = clear_in ? 16'h0000 : cnt_in;
      if (enable_in && event_in && next_cnt_out != `FES_HALF_MAX)
      begin
         next_cnt_out = next_cnt_out + 16'h0001;
      end
      // Peak survives the recall, so compare against the raw count
      next_peak_out = peak_in;
      if (cnt_in > peak_in)
      begin
         next_peak_out = cnt_in;
      end
      if (next_cnt_out > next_peak_out)
      begin
         next_peak_out = next_cnt_out;
      end
   end
endmodule : fes_count_step

// ### verilog/fes_supervisor.sv
// Flow error supervisor: checks, counters, interrupt, level regulation
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "fes_defs.svh"
module fes_supervisor (
   input wire logic CLK_IN,
   input wire logic RESETN_IN,
   input wire logic HSEL_IN,
   input wire logic [31:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [2:0] HSIZE_IN,
   input wire logic [31:0] HWDATA_IN,
   input wire logic HREADY_IN,
   output logic HREADYOUT_OUT,
   output logic [31:0] HRDATA_OUT,
   output logic HRESP_OUT,
   input wire logic MEAS_VALID_IN,
   input wire logic [31:0] MEAS_FLAGS_IN,
   input wire logic [31:0] FLOW_IN,
   input wire logic [31:0] SOUND_VEL_IN,
   input wire logic [31:0] VEL_MAX_IN,
   input wire logic [31:0] VEL_MIN_IN,
   input wire logic [31:0] SUMMED_TIME_OF_FLIGHT_IN,
   input wire logic [15:0] AMPLITUDE_IN,
   input wire logic HOUR_TICK_IN,
   input wire logic [31:0] CALC_CS_DATA2_IN,
   input wire logic [31:0] CALC_CS_USER_IN,
   input wire logic [31:0] CALC_CS_VENDOR_IN,
   output logic [31:0] FLOW_OUT,
   output logic PULSE_ERROR_OUT,
   output logic IRQ_OUT,
   output logic [15:0] LEVEL_OUT,
   output logic TRUSTED_SEL_OUT,
   output logic LEVEL_ADJUST_OUT,
   output logic PWR_REGULATE_OUT
);
   fes_pkg::fes_state_t st;
   fes_pkg::fes_state_t n;
   logic [15:0] cnt_cur [4];
   logic [15:0] peak_cur [4];
   logic [15:0] cnt_nxt [4];
   logic [15:0] peak_nxt [4];
   logic [3:0] ev;
   logic [31:0] err_word;
   logic [31:0] base_a;
   logic [31:0] base_b;
   logic flow_over;
   logic vel_err;
   logic cs_err;
   logic any_err;
   logic [32:0] sum_diff;
   logic [31:0] sum_dev;
   logic [31:0] expected;
   logic [31:0] ratio_prod;
   logic [15:0] trusted_val;
   logic [1:0] method;
   logic long_term;
   logic test_now;

   // Read mux for the address phase
   function automatic logic [31:0] read_reg(input logic [7:0] idx,
                                            input fes_pkg::fes_state_t s);
      logic [31:0] v;
      v = `FES_WORD_ZERO;
      unique case (idx)
         `FES_IDX_OPTION: v = s.option;
         `FES_IDX_STATUS: v = s.err_word;
         `FES_IDX_CNT1_MASK: v = s.cnt1_mask;
         `FES_IDX_CNT2_MASK: v = s.cnt2_mask;
         `FES_IDX_STORE_A: v = s.store_a;
         `FES_IDX_STORE_B: v = s.store_b;
         `FES_IDX_RESULT_A: v = s.result_a;
         `FES_IDX_RESULT_B: v = s.result_b;
         `FES_IDX_TRUSTED: v = s.trusted;
         `FES_IDX_OFFSET_TIME: v = s.offset_time;
         `FES_IDX_VAR_LIM: v = s.var_lim;
         `FES_IDX_IRQ_MASK: v = s.irq_mask;
         `FES_IDX_PW_NOM: v = s.pw_nom;
         `FES_IDX_MAX_FLOW: v = s.max_flow;
         `FES_IDX_START_LEVEL: v = s.start_level;
         `FES_IDX_IEH: v = s.ieh;
         `FES_IDX_CS_DATA2: v = s.cs_data2;
         `FES_IDX_CS_USER: v = s.cs_user;
         `FES_IDX_CS_VENDOR: v = s.cs_vendor;
         default: v = `FES_WORD_ZERO; // Unmapped reads as zero
      endcase
      return v;
   endfunction : read_reg

   // Store words as written this cycle, so a write and a count merge
   always_comb
   begin
      base_a = st.store_a;
      base_b = st.store_b;
      if (st.wr_pend && st.wr_idx == `FES_IDX_STORE_A)
      begin
         base_a = HWDATA_IN;
      end
      if (st.wr_pend && st.wr_idx == `FES_IDX_STORE_B)
      begin
         base_b = HWDATA_IN;
      end
   end

   // Error checks of the current measurement
   always_comb
   begin
      flow_over = {1'b0, FLOW_IN} > {st.max_flow, 1'b0};
      vel_err = st.option[`FES_OPT_VEL_CHECK] &&
                (SOUND_VEL_IN > VEL_MAX_IN ||
                 SOUND_VEL_IN < VEL_MIN_IN);
      cs_err = CALC_CS_DATA2_IN != st.cs_data2 ||
               CALC_CS_USER_IN != st.cs_user ||
               CALC_CS_VENDOR_IN != st.cs_vendor;
      err_word = MEAS_FLAGS_IN;
      err_word[`FES_ERR_FLOW_BIT] = MEAS_FLAGS_IN[`FES_ERR_FLOW_BIT] |
         (flow_over & ~st.option[`FES_OPT_DOUBLE_MAX_KEEP]);
      err_word[`FES_ERR_VEL_BIT] = MEAS_FLAGS_IN[`FES_ERR_VEL_BIT] | vel_err;
      err_word[`FES_ERR_CS_BIT] = MEAS_FLAGS_IN[`FES_ERR_CS_BIT] | cs_err;
      any_err = |err_word;
      // Counter events: masks 1 and 2, hardware error, any error
      ev[0] = |(err_word & st.cnt1_mask);
      ev[1] = |(err_word & st.cnt2_mask);
      ev[2] = err_word[`FES_ERR_HW_BIT];
      ev[3] = any_err;
   end

   // Halves: counter 1 low and 2 high of store A, hardware low of store B
   assign cnt_cur[0] = base_a[15:0];
   assign cnt_cur[1] = base_a[31:16];
   assign cnt_cur[2] = base_b[15:0];
   assign cnt_cur[3] = base_b[31:16];
   assign peak_cur[0] = st.result_a[15:0];
   assign peak_cur[1] = st.result_a[31:16];
   assign peak_cur[2] = st.result_b[15:0];
   assign peak_cur[3] = st.result_b[31:16];

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_cnt
         fes_count_step u_step (
            .cnt_in(cnt_cur[gi]),
            .peak_in(peak_cur[gi]),
            .event_in(ev[gi] & MEAS_VALID_IN),
            .clear_in(HOUR_TICK_IN),
            .enable_in(st.option[`FES_OPT_CNT_ENABLE]),
            .next_cnt_out(cnt_nxt[gi]),
            .next_peak_out(peak_nxt[gi])
         );
      end
   endgenerate

   // Level arithmetic: trusted level and sum deviation
   always_comb
   begin
      method = {st.option[`FES_OPT_METHOD_HI], st.option[`FES_OPT_METHOD_LO]};
      ratio_prod = st.amp * st.trusted[15:0];
      if (st.option[`FES_OPT_LEVEL_RATIO])
      begin
         trusted_val = ratio_prod[31:16];
      end
      else
      begin
         trusted_val = {8'h00, st.trusted[7:0]};
      end
      expected = st.summed_time_of_flight_ref;
      if (method == `FES_METHOD_OFFSET)
      begin
         expected = st.summed_time_of_flight_ref + st.offset_time;
      end
      sum_diff = {1'b0, SUMMED_TIME_OF_FLIGHT_IN} - {1'b0, expected};
      sum_dev = sum_diff[32] ? expected - SUMMED_TIME_OF_FLIGHT_IN : sum_diff[31:0];
      long_term = st.err_run >= `FES_LONG_TERM_CNT;
      if (st.option[`FES_OPT_LEVEL_TEST_REGULAR])
      begin
         test_now = st.meas_cnt == `FES_LEVEL_SLOT;
      end
      else
      begin
         test_now = any_err;
      end
   end

   // Next state of the whole block
   always_comb
   begin
      n = st;
      n.irq = 1'b0;
      n.lvl_adj = 1'b0;
      n.pwr_reg = 1'b0;
      n.hready = 1'b1;
      // Address phase: zero wait, read data ready for the data phase
      n.wr_pend = 1'b0;
      if (HSEL_IN && HTRANS_IN[1] && HREADY_IN)
      begin
         n.wr_pend = HWRITE_IN;
         n.wr_idx = HADDR_IN[9:2];
         n.rdata = HWRITE_IN ? st.rdata : read_reg(HADDR_IN[9:2], st);
      end
      // Data phase writes; status and results are read only
      if (st.wr_pend)
      begin
         unique case (st.wr_idx)
            `FES_IDX_OPTION: n.option = HWDATA_IN;
            `FES_IDX_CNT1_MASK: n.cnt1_mask = HWDATA_IN;
            `FES_IDX_CNT2_MASK: n.cnt2_mask = HWDATA_IN;
            `FES_IDX_TRUSTED: n.trusted = HWDATA_IN;
            `FES_IDX_OFFSET_TIME: n.offset_time = HWDATA_IN;
            `FES_IDX_VAR_LIM: n.var_lim = HWDATA_IN;
            `FES_IDX_IRQ_MASK: n.irq_mask = HWDATA_IN;
            `FES_IDX_PW_NOM: n.pw_nom = HWDATA_IN;
            `FES_IDX_MAX_FLOW: n.max_flow = HWDATA_IN;
            `FES_IDX_START_LEVEL: n.start_level = HWDATA_IN;
            `FES_IDX_IEH: n.ieh = HWDATA_IN;
            `FES_IDX_CS_DATA2: n.cs_data2 = HWDATA_IN;
            `FES_IDX_CS_USER: n.cs_user = HWDATA_IN;
            `FES_IDX_CS_VENDOR: n.cs_vendor = HWDATA_IN;
            default: n.option = st.option; // Others ignored
         endcase
      end
      // Counters always pass through the step; written value kept
      n.store_a = {cnt_nxt[1], cnt_nxt[0]};
      n.store_b = {cnt_nxt[3], cnt_nxt[2]};
      n.result_a = {peak_nxt[1], peak_nxt[0]};
      n.result_b = {peak_nxt[3], peak_nxt[2]};
      if (MEAS_VALID_IN)
      begin
         n.err_word = err_word;
         n.meas_cnt = st.meas_cnt + 5'h01;
         n.flow = FLOW_IN;
         if (flow_over && !st.option[`FES_OPT_DOUBLE_MAX_KEEP])
         begin
            n.flow = `FES_WORD_ZERO;
         end
         // Hardware errors only reach the pulse pin when selected
         n.pulse_err = !st.option[`FES_OPT_PULSE_ERR_SUPPRESS] &&
            (|(err_word & ~(32'h1 << `FES_ERR_HW_BIT)) ||
             (err_word[`FES_ERR_HW_BIT] &&
              st.option[`FES_OPT_HW_ERR_ON_PULSE]));
         // Only newly set masked flags interrupt, a held flag does not
         n.irq = st.ieh[`FES_IEH_SYNC_BIT] &&
                 |(err_word & ~st.err_word & st.irq_mask);
         if (any_err)
         begin
            if (!long_term)
            begin
               n.err_run = st.err_run + 6'h01;
            end
         end
         else
         begin
            n.err_run = 6'h00;
            n.amp = AMPLITUDE_IN;
         end
         // Width ratio regulation half a period after level slot
         if (st.pw_nom != `FES_WORD_ZERO && !any_err &&
             st.meas_cnt == `FES_PWR_SLOT)
         begin
            n.pwr_reg = 1'b1;
         end
         unique case (st.lv_mode)
            fes_pkg::LV_OPERATE:
            begin
               if (!any_err)
               begin
                  n.summed_time_of_flight_ref = SUMMED_TIME_OF_FLIGHT_IN;
               end
               if (long_term && st.meas_cnt == `FES_LEVEL_SLOT)
               begin
                  n.lv_mode = fes_pkg::LV_FALLBACK;
               end
               else if (method != `FES_METHOD_FIXED && !long_term &&
                        test_now)
               begin
                  n.lv_mode = fes_pkg::LV_TRUSTED;
               end
            end
            fes_pkg::LV_TRUSTED:
            begin
               n.lv_mode = fes_pkg::LV_OPERATE;
               if (!any_err)
               begin
                  n.started = 1'b1;
                  if (sum_dev > st.var_lim)
                  begin
                     n.op_level = trusted_val;
                     n.lvl_adj = 1'b1;
                  end
                  else if (!st.started)
                  begin
                     n.op_level = st.start_level[15:0];
                  end
               end
            end
            fes_pkg::LV_FALLBACK:
            begin
               n.lv_mode = fes_pkg::LV_OPERATE;
               if (!any_err)
               begin
                  n.op_level = st.start_level[15:0];
                  n.started = 1'b1;
               end
            end
         endcase
         // Level for the next measurement; stands until then
         n.trusted_sel = n.lv_mode == fes_pkg::LV_TRUSTED;
         if (n.lv_mode == fes_pkg::LV_TRUSTED)
         begin
            n.level = trusted_val;
         end
         else if (n.lv_mode == fes_pkg::LV_FALLBACK || !n.started)
         begin
            n.level = n.start_level[15:0];
         end
         else
         begin
            n.level = n.op_level;
         end
      end
   end

   // State register; all fields reset to constants
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         st <= '0;
         st.hready <= 1'b1;
         st.lv_mode <= fes_pkg::LV_OPERATE;
      end
      else
      begin
         st <= n;
      end
   end

   // Outputs straight from the state flops; HRESP_OUT tied to okay
   assign HREADYOUT_OUT = st.hready;
   assign HRDATA_OUT = st.rdata;
   assign HRESP_OUT = 1'b0;
   assign FLOW_OUT = st.flow;
   assign PULSE_ERROR_OUT = st.pulse_err;
   assign IRQ_OUT = st.irq;
   assign LEVEL_OUT = st.level;
   assign TRUSTED_SEL_OUT = st.trusted_sel;
   assign LEVEL_ADJUST_OUT = st.lvl_adj;
   assign PWR_REGULATE_OUT = st.pwr_reg;
endmodule : fes_supervisor

// ### sim/fes_supervisor_props.sv
// Port-level checker of the flow error supervisor
`timescale 1ns/1ps
module fes_supervisor_props (
   input wire logic CLK_IN,
   input wire logic RESETN_IN,
   input wire logic HSEL_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic HREADY_IN,
   input wire logic HREADYOUT_OUT,
   input wire logic [31:0] HRDATA_OUT,
   input wire logic HRESP_OUT,
   input wire logic MEAS_VALID_IN,
   input wire logic [31:0] FLOW_IN,
   input wire logic [31:0] FLOW_OUT,
   input wire logic PULSE_ERROR_OUT,
   input wire logic IRQ_OUT,
   input wire logic [15:0] LEVEL_OUT,
   input wire logic LEVEL_ADJUST_OUT,
   input wire logic PWR_REGULATE_OUT
);
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RESETN_IN);
   // Bus answers with no wait and never an error
   a_ready_zero_wait: assert property (HREADYOUT_OUT)
      else $error("hreadyout went low");
   a_resp_okay: assert property (HRESP_OUT == 1'b0)
      else $error("response not okay");
   // Read data must stand until the next read is taken
   a_rdata_hold: assert property (!$past(HSEL_IN && HTRANS_IN[1]
      && !HWRITE_IN && HREADY_IN) |-> $stable(HRDATA_OUT))
      else $error("read data changed without a read");
   // Flow result is either the input or forced to zero
   a_flow_clip: assert property (
      MEAS_VALID_IN |=> FLOW_OUT == $past(FLOW_IN) || FLOW_OUT == 32'h0)
      else $error("flow result neither input nor zero");
   // Results move only on a finished measurement
   a_pulse_hold: assert property (
      !$past(MEAS_VALID_IN) |-> $stable(PULSE_ERROR_OUT))
      else $error("pulse error changed between measurements");
   a_level_hold: assert property (
      !$past(MEAS_VALID_IN) |-> $stable(LEVEL_OUT))
      else $error("level changed between measurements");
   a_irq_cause: assert property (
      IRQ_OUT |-> $past(MEAS_VALID_IN))
      else $error("interrupt without a measurement");
   a_adjust_cause: assert property (
      LEVEL_ADJUST_OUT |-> $past(MEAS_VALID_IN))
      else $error("level adjust without a measurement");
   a_pwr_cause: assert property (
      PWR_REGULATE_OUT |-> $past(MEAS_VALID_IN))
      else $error("width step without a measurement");
   // Width steps are 32 measurements apart, so never close together
   a_pwr_gap: assert property (
      PWR_REGULATE_OUT |=> !PWR_REGULATE_OUT [*8])
      else $error("width steps too close");
endmodule : fes_supervisor_props

// ### sim/fes_host_model.sv
// Host controller model: AHB-Lite master and interrupt counter
`timescale 1ns/1ps
module fes_host_model (
   input wire logic clk_in,
   input wire logic hready_in,
   input wire logic [31:0] hrdata_in,
   input wire logic irq_in,
   output logic [31:0] haddr_out,
   output logic [1:0] htrans_out,
   output logic hwrite_out,
   output logic [31:0] hwdata_out,
   output int irq_count_out
);
   // Idle bus from time zero
   initial
   begin
      haddr_out = 32'h0;
      htrans_out = 2'h0;
      hwrite_out = 1'b0;
      hwdata_out = 32'h0;
   end
   // Count interrupt pulses; one per cycle high
   always @(posedge clk_in)
      if (irq_in) irq_count_out <= irq_count_out + 1;
   // Bounded wait so a dead slave cannot hang the run
   task automatic wait_ready(output logic ok);
      ok = 1'b0;
      for (int n = 0; n < 16 && !ok; n++)
      begin
         @(posedge clk_in);
         ok = hready_in;
      end
   endtask : wait_ready
   // One single word transfer, address then data phase
   task automatic xfer(input logic wr, input logic [7:0] idx,
      input logic [31:0] wd, output logic [31:0] rd, output logic ok);
      logic ok1;
      haddr_out <= {22'h0, idx, 2'h0};
      htrans_out <= 2'h2;
      hwrite_out <= wr;
      wait_ready(ok1);
      htrans_out <= 2'h0;
      hwdata_out <= wd;
      wait_ready(ok);
      rd = hrdata_in;
      ok = ok & ok1;
   endtask : xfer
endmodule : fes_host_model

// ### sim/tb_flow_error_supervisor.sv
// Self-checking bench of the flow error supervisor
`timescale 1ns/1ps
`include "fes_defs.svh"
module tb_flow_error_supervisor;
   localparam logic [31:0] hw_f = 32'h1 << `FES_ERR_HW_BIT;
   logic clk_in = 1'b0;
   logic resetn = 1'b0;
   logic mvalid = 1'b0;
   logic tick = 1'b0;
   logic [31:0] flags = 32'h0, flow = 32'h0, vel = 32'h0;
   logic [31:0] vel_max = 32'h0, vel_min = 32'h0, summed_time_of_flight = 32'h0;
   logic [31:0] calc [3] = '{32'h0, 32'h0, 32'h0};
   logic [31:0] haddr, hwdata, hrdata, flow_out;
   logic [1:0] htrans;
   logic hwrite, hready, hresp, pulse_out, irq_out, tsel, adj_out, pwr_out;
   logic [15:0] level_out, amp = 16'h0100;
   int irq_cnt;
   int n_mismatch = 0;
   int check_count = 0;
   fes_supervisor dut (.CLK_IN(clk_in), .RESETN_IN(resetn),
      .HSEL_IN(1'b1), .HADDR_IN(haddr), .HTRANS_IN(htrans),
      .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
      .HREADY_IN(hready), .HREADYOUT_OUT(hready), .HRDATA_OUT(hrdata),
      .HRESP_OUT(hresp), .MEAS_VALID_IN(mvalid), .MEAS_FLAGS_IN(flags),
      .FLOW_IN(flow), .SOUND_VEL_IN(vel), .VEL_MAX_IN(vel_max),
      .VEL_MIN_IN(vel_min), .SUMMED_TIME_OF_FLIGHT_IN(summed_time_of_flight), .AMPLITUDE_IN(amp),
      .HOUR_TICK_IN(tick), .CALC_CS_DATA2_IN(calc[0]),
      .CALC_CS_USER_IN(calc[1]), .CALC_CS_VENDOR_IN(calc[2]),
      .FLOW_OUT(flow_out), .PULSE_ERROR_OUT(pulse_out),
      .IRQ_OUT(irq_out), .LEVEL_OUT(level_out), .TRUSTED_SEL_OUT(tsel),
      .LEVEL_ADJUST_OUT(adj_out), .PWR_REGULATE_OUT(pwr_out));
   fes_host_model host (.clk_in(clk_in), .hready_in(hready),
      .hrdata_in(hrdata), .irq_in(irq_out), .haddr_out(haddr),
      .htrans_out(htrans), .hwrite_out(hwrite), .hwdata_out(hwdata),
      .irq_count_out(irq_cnt));
   // 40 MHz clock
   initial
   begin
      forever #12.5 clk_in = ~clk_in;
   end
   task automatic tally_and_finish(input logic hung);
      if (hung) n_mismatch++;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string nm, input logic [31:0] exp,
      input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] r;
      logic ok;
      host.xfer(1'b1, idx, d, r, ok);
      if (!ok) tally_and_finish(1'b1);
   endtask : wr
   task automatic rd(input string nm, input logic [7:0] idx,
      input logic [31:0] e);
      logic [31:0] r;
      logic ok;
      host.xfer(1'b0, idx, 32'h0, r, ok);
      if (!ok) tally_and_finish(1'b1);
      chk(nm, e, r);
   endtask : rd
   // One measurement; results are looked at one cycle later
   task automatic meas(input logic [31:0] f, input logic [31:0] fl);
      flags <= f;
      flow <= fl;
      mvalid <= 1'b1;
      @(posedge clk_in);
      mvalid <= 1'b0;
      #1;
   endtask : meas
   task automatic t_reset;
      chk("hreadyout", 32'h1, {31'h0, hready});
      chk("hresp", 32'h0, {31'h0, hresp});
      rd("option", `FES_IDX_OPTION, 32'h0);
      rd("unmapped", 8'h40, 32'h0);
      wr(`FES_IDX_STATUS, 32'hffffffff);
      rd("status read only", `FES_IDX_STATUS, 32'h0);
      wr(`FES_IDX_START_LEVEL, 32'h55);
      meas(32'h0, 32'h0);
      chk("start level", 32'h55, {16'h0, level_out});
      chk("fixed method", 32'h0, {31'h0, tsel});
      $display("t_reset done");
   endtask : t_reset
   task automatic t_flow;
      wr(`FES_IDX_MAX_FLOW, 32'h64);
      meas(32'h0, 32'hc9);
      chk("flow clipped", 32'h0, flow_out);
      rd("flow error", `FES_IDX_STATUS, 32'h1 << `FES_ERR_FLOW_BIT);
      meas(32'h0, 32'hc8);
      chk("flow at limit", 32'hc8, flow_out);
      wr(`FES_IDX_OPTION, 32'h1 << `FES_OPT_DOUBLE_MAX_KEEP);
      meas(32'h0, 32'hc9);
      chk("flow kept", 32'hc9, flow_out);
      rd("no flow error", `FES_IDX_STATUS, 32'h0);
      $display("t_flow done");
   endtask : t_flow
   // Suppress and hardware bits against a hardware or other error
   task automatic t_pulse;
      logic e;
      for (int i = 0; i < 8; i++)
      begin
         wr(`FES_IDX_OPTION, {9'h0, i[1], i[0], 21'h0});
         e = !i[0] && (i[2] || i[1]);
         meas(i[2] ? 32'h1 : hw_f, 32'h0);
         chk("pulse error", {31'h0, e}, {31'h0, pulse_out});
      end
      $display("t_pulse done");
   endtask : t_pulse
   task automatic t_checks;
      vel_max <= 32'ha;
      vel_min <= 32'h5;
      wr(`FES_IDX_OPTION, 32'h1 << `FES_OPT_VEL_CHECK);
      for (int i = 0; i < 4; i++)
      begin
         if (i == 3) wr(`FES_IDX_OPTION, 32'h0);
         vel <= (i == 1) ? 32'h4 : (i == 2) ? 32'h7 : 32'hb;
         meas(32'h0, 32'h0);
         rd("velocity error", `FES_IDX_STATUS,
            (i < 2) ? 32'h1 << `FES_ERR_VEL_BIT : 32'h0);
      end
      // Each reference word against its computed checksum
      for (int k = 0; k < 3; k++)
      begin
         wr(8'(`FES_IDX_CS_DATA2 + k), 32'h1230 + 32'(k));
         calc[k] <= 32'h1238 + 32'(k);
         meas(32'h0, 32'h0);
         rd("cs error", `FES_IDX_STATUS, 32'h1 << `FES_ERR_CS_BIT);
         calc[k] <= 32'h1230 + 32'(k);
         meas(32'h0, 32'h0);
         rd("cs match", `FES_IDX_STATUS, 32'h0);
      end
      $display("t_checks done");
   endtask : t_checks
   task automatic t_count;
      wr(`FES_IDX_STORE_A, 32'h0);
      wr(`FES_IDX_STORE_B, 32'h0);
      wr(`FES_IDX_CNT1_MASK, 32'h1);
      wr(`FES_IDX_CNT2_MASK, hw_f);
      wr(`FES_IDX_OPTION, 32'h1 << `FES_OPT_CNT_ENABLE);
      meas(32'h1, 32'h0);
      meas(hw_f, 32'h0);
      meas(hw_f | 32'h1, 32'h0);
      meas(32'h2, 32'h0);
      meas(32'h1, 32'h0);
      rd("store a", `FES_IDX_STORE_A, 32'h00020003);
      rd("store b", `FES_IDX_STORE_B, 32'h00050002);
      rd("result a", `FES_IDX_RESULT_A, 32'h00020003);
      rd("result b", `FES_IDX_RESULT_B, 32'h00050002);
      tick <= 1'b1;
      @(posedge clk_in);
      tick <= 1'b0;
      meas(32'h1, 32'h0);
      rd("store a", `FES_IDX_STORE_A, 32'h00000001);
      rd("store b", `FES_IDX_STORE_B, 32'h00010000);
      rd("result a", `FES_IDX_RESULT_A, 32'h00020003);
      wr(`FES_IDX_STORE_B, 32'hfffe0000);
      meas(32'h1, 32'h0);
      meas(32'h1, 32'h0);
      rd("store b sat", `FES_IDX_STORE_B, 32'hffff0000);
      wr(`FES_IDX_OPTION, 32'h0);
      meas(32'h1, 32'h0);
      rd("store a off", `FES_IDX_STORE_A, 32'h00000003);
      $display("t_count done");
   endtask : t_count
   // Newly set masked flag only, and only while enabled
   task automatic t_irq;
      wr(`FES_IDX_IEH, 32'h1 << `FES_IEH_SYNC_BIT);
      wr(`FES_IDX_IRQ_MASK, hw_f);
      for (int i = 0; i < 7; i++)
      begin
         if (i == 4) wr(`FES_IDX_IRQ_MASK, 32'h1);
         if (i == 5) wr(`FES_IDX_IEH, 32'h0);
         if (i == 5) wr(`FES_IDX_IRQ_MASK, hw_f);
         meas((i == 1 || i == 2 || i == 4 || i == 6) ? hw_f : 32'h0, 32'h0);
         chk("irq", {31'h0, i == 1}, {31'h0, irq_out});
      end
      chk("irq count", 32'h1, 32'(irq_cnt));
      $display("t_irq done");
   endtask : t_irq
   task automatic t_pwr;
      int p = 0;
      wr(`FES_IDX_PW_NOM, 32'h1);
      repeat (32)
      begin
         meas(32'h0, 32'h0);
         p += pwr_out;
      end
      chk("width steps", 32'h1, 32'(p));
      $display("t_pwr done");
   endtask : t_pwr
   task automatic t_level;
      wr(`FES_IDX_TRUSTED, 32'h8040);
      wr(`FES_IDX_VAR_LIM, 32'h10);
      wr(`FES_IDX_OFFSET_TIME, 32'h20);
      wr(`FES_IDX_OPTION, 32'h1 << `FES_OPT_METHOD_LO);
      meas(32'h1, 32'h0);
      chk("trusted level", 32'h40, {16'h0, level_out});
      chk("trusted select", 32'h1, {31'h0, tsel});
      summed_time_of_flight <= 32'hf;
      meas(32'h0, 32'h0);
      chk("within limit", 32'h55, {16'h0, level_out});
      wr(`FES_IDX_OPTION, 32'h6 << `FES_OPT_METHOD_LO);
      meas(32'h1, 32'h0);
      chk("ratio level", 32'h80, {16'h0, level_out});
      meas(32'h0, 32'h0);
      chk("offset adjust", 32'h1, {31'h0, adj_out});
      $display("t_level done");
   endtask : t_level
   // Main sequence after a 16 cycle reset
   initial
   begin
      repeat (16) @(posedge clk_in);
      resetn <= 1'b1;
      @(posedge clk_in);
      t_reset;
      t_flow;
      t_pulse;
      t_checks;
      t_count;
      t_irq;
      t_pwr;
      t_level;
      tally_and_finish(1'b0);
   end
endmodule : tb_flow_error_supervisor
bind fes_supervisor fes_supervisor_props u_props (.CLK_IN(CLK_IN),
   .RESETN_IN(RESETN_IN), .HSEL_IN(HSEL_IN), .HTRANS_IN(HTRANS_IN),
   .HWRITE_IN(HWRITE_IN), .HREADY_IN(HREADY_IN),
   .HREADYOUT_OUT(HREADYOUT_OUT), .HRDATA_OUT(HRDATA_OUT),
   .HRESP_OUT(HRESP_OUT), .MEAS_VALID_IN(MEAS_VALID_IN),
   .FLOW_IN(FLOW_IN), .FLOW_OUT(FLOW_OUT),
   .PULSE_ERROR_OUT(PULSE_ERROR_OUT), .IRQ_OUT(IRQ_OUT),
   .LEVEL_OUT(LEVEL_OUT), .LEVEL_ADJUST_OUT(LEVEL_ADJUST_OUT),
   .PWR_REGULATE_OUT(PWR_REGULATE_OUT));
